// *** common/sct_pkg.sv ***
// Purpose: constants and types of the chip-select timing and transfer core
// Assumes: one 100 MHz module clock, no register bus
// Notes: control bits of the combined transmit register sit in byte 3
// ----------------------------------------------------------------
// How it works
// - Master setup delay spans 3 to 257 cycles
// - Setup lasts field plus 2, zero skips
// - Setup only with chip select, previous hold clear
// - Master hold after last edge, 2 to 256
// - Hold lasts field plus 1, zero skips
// - Phase 0 adds half serial clock period
// - Hold only with chip select, current hold clear
// - Enabled inter-word wait lasts field plus 2
// - Wait follows hold end, or last edge when hold is skipped
// - Full 32-bit write uses new wait settings
// - Kept chip select skips hold and setup
// - Module reset clears only current keep bit
// - Slave control writes force format select to 0
// - Master when both mode bits 1, slave 0
// - Master drives clock, slave-in; slave drives slave-out
// - Master data byte writes start a transfer
// - Each clock pulse moves one bit each way
// - Received word stored right-justified in buffer
// - Slave data writes mark slave ready
// ----------------------------------------------------------------
package sct_pkg;
    localparam int FMT_SETS = 4;
    localparam int CTRL_BYTE = 3;
    localparam int KEEP_BIT = 28;
    localparam int INTER_WORD_DELAY_EN_BIT = 26;
    localparam int FSEL_LSB = 24;
    localparam logic [4:0] DATA_BITS = 5'h10;
    localparam logic [9:0] SETUP_EXTRA = 10'h002;
    localparam logic [9:0] HOLD_EXTRA = 10'h001;
    localparam logic [9:0] WAIT_EXTRA = 10'h002;
    localparam logic [3:0] SYNC_RST = 4'h1;
    localparam logic KEEP_RST = 1'b0;

    typedef struct packed {
        logic [7:0] clock_divider;
        logic [4:0] word_length;
        logic [5:0] inter_word_delay;
        logic phase;
        logic polarity;
    } sct_fmt_s;

    typedef struct packed {
        logic [15:0] data;
        logic wait_en;
        logic [5:0] wait_len;
    } sct_pend_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_SHIFT = 3'b010,
        ST_HOLD = 3'b011,
        ST_WAIT = 3'b100
    } sct_state_e;
endpackage : sct_pkg

// *** src/sct_core.sv ***
// Purpose: master and slave transfer core with chip-select timing
// Assumes: settings stable while enabled
// Notes: pins are split into input, output and active-low enable
`timescale 1ns/10ps
module sct_core (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Mode and configuration
    input wire logic module_reset_n_i,
    input wire logic enable_i,
    input wire logic clock_source_sel_i,
    input wire logic master_sel_i,
    input wire logic cs_pin_en_i,
    input wire logic [7:0] cs_setup_delay_i,
    input wire logic [7:0] cs_hold_delay_i,
    input wire sct_pkg::sct_fmt_s [3:0] fmt_i,
    // Transmit register writes
    input wire logic tx_wr_i,
    input wire logic tx_to_ctrl_i,
    input wire logic [3:0] tx_be_i,
    input wire logic [31:0] tx_wdata_i,
    // Receive and status
    output logic [15:0] rx_data_o,
    output logic rx_valid_o,
    output logic busy_o,
    output logic slave_ready_o,
    output logic cs_keep_o,
    // Serial pins
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe_n_o,
    input wire logic slave_in_pin_i,
    output logic slave_in_pin_o,
    output logic slave_in_pin_oe_n_o,
    input wire logic slave_out_pin_i,
    output logic slave_out_pin_o,
    output logic slave_out_pin_oe_n_o,
    input wire logic chip_select_pin_n_i,
    output logic chip_select_pin_n_o,
    output logic chip_select_pin_oe_n_o
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    wire [3:0] pin_raw = {serial_clock_pin_i, slave_in_pin_i, slave_out_pin_i, chip_select_pin_n_i};
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic sclk_d_reg;

    for (genvar g = 0; g < 4; g++) begin : g_sync
        always_ff @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                sync1_reg[g] <= sct_pkg::SYNC_RST[g];
                sync2_reg[g] <= sct_pkg::SYNC_RST[g];
            end else begin
                sync1_reg[g] <= pin_raw[g];
                sync2_reg[g] <= sync1_reg[g];
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sclk_d_reg <= 1'b0;
        end else begin
            sclk_d_reg <= sync2_reg[3];
        end
    end

    function automatic logic [15:0] len_mask(input logic [4:0] len);
        len_mask = 16'(({1'b0, 16'h0} | 17'h1) << len) - 16'h1;
    endfunction : len_mask

    // ----------------------------------------------------------------
    // Mode and write decode
    // ----------------------------------------------------------------
    sct_pkg::sct_state_e st_reg;
    logic cur_keep_reg;
    logic prev_keep_reg;
    logic inter_word_delay_en_reg;
    logic [1:0] fsel_reg;
    logic pend_v_reg;
    sct_pkg::sct_pend_s pend_reg;
    logic cs_act_reg;
    logic w_en_reg;
    logic [5:0] w_len_reg;
    logic [9:0] cnt_reg;
    logic [8:0] tick_reg;
    logic sclk_reg;
    logic [5:0] edge_reg;
    logic rxbit_reg;
    logic [15:0] sh_reg;

    wire is_master = clock_source_sel_i & master_sel_i;
    wire is_slave = ~clock_source_sel_i & ~master_sel_i;
    wire run = enable_i & module_reset_n_i;
    wire data_wr = tx_wr_i & (|tx_be_i[1:0]);
    wire ctrl_wr = tx_wr_i & tx_to_ctrl_i & tx_be_i[sct_pkg::CTRL_BYTE];
    wire full_wr = tx_wr_i & tx_to_ctrl_i & (&tx_be_i);
    wire [1:0] new_fsel = is_master ? tx_wdata_i[sct_pkg::FSEL_LSB+:2] : 2'h0;
    wire sct_pkg::sct_fmt_s fmt = fmt_i[is_master ? fsel_reg : 2'h0];
    wire [8:0] half = {1'b0, fmt.clock_divider} + 9'h001;
    wire sel = ~cs_pin_en_i | ~sync2_reg[0];
    wire m_start = (st_reg == sct_pkg::ST_IDLE) & pend_v_reg & is_master & run;
    wire s_load = data_wr & is_slave;
    wire setup_on = cs_pin_en_i & ~prev_keep_reg & (|cs_setup_delay_i) & ~cs_act_reg;
    wire hold_on = cs_pin_en_i & ~cur_keep_reg & (|cs_hold_delay_i);
    wire [9:0] setup_len = {2'h0, cs_setup_delay_i} + sct_pkg::SETUP_EXTRA;
    wire [9:0] hold_len = {2'h0, cs_hold_delay_i} + sct_pkg::HOLD_EXTRA + (fmt.phase ? 10'h0 : {1'b0, half});
    wire [9:0] wait_len = {4'h0, w_len_reg} + sct_pkg::WAIT_EXTRA;
    wire mtick = (st_reg == sct_pkg::ST_SHIFT) & (tick_reg == 9'h001);
    wire sedge = is_slave & run & sel & (sync2_reg[3] ^ sclk_d_reg);
    wire ev = is_master ? mtick : sedge;
    wire lead = ev & ~edge_reg[0];
    wire last = ev & (edge_reg == 6'({fmt.word_length, 1'b0} - 6'h01));
    wire samp = fmt.phase ? ~lead : lead;
    wire din = is_master ? sync2_reg[1] : sync2_reg[2];
    wire [15:0] mask = len_mask(fmt.word_length);
    wire [15:0] word_done = {sh_reg[14:0], fmt.phase ? din : rxbit_reg} & mask;
    wire [15:0] load_src = is_master ? pend_reg.data : tx_wdata_i[15:0];
    wire [15:0] sh_load = load_src << (sct_pkg::DATA_BITS - fmt.word_length);

    // ----------------------------------------------------------------
    // Control bits and pending word
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cur_keep_reg <= sct_pkg::KEEP_RST;
            prev_keep_reg <= sct_pkg::KEEP_RST;
            inter_word_delay_en_reg <= 1'b0;
            fsel_reg <= 2'h0;
        end else if (!module_reset_n_i) begin
            cur_keep_reg <= sct_pkg::KEEP_RST;
        end else if (ctrl_wr) begin
            prev_keep_reg <= cur_keep_reg;
            cur_keep_reg <= tx_wdata_i[sct_pkg::KEEP_BIT];
            inter_word_delay_en_reg <= tx_wdata_i[sct_pkg::INTER_WORD_DELAY_EN_BIT];
            fsel_reg <= new_fsel;
        end else if (tx_wr_i && tx_to_ctrl_i && is_slave) begin
            fsel_reg <= 2'h0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pend_v_reg <= 1'b0;
            pend_reg <= '0;
        end else begin
            if (m_start || !module_reset_n_i) begin
                pend_v_reg <= 1'b0;
            end
            if (data_wr && is_master && module_reset_n_i) begin
                pend_v_reg <= 1'b1;
                pend_reg.data <= tx_wdata_i[15:0];
                pend_reg.wait_en <= full_wr ? tx_wdata_i[sct_pkg::INTER_WORD_DELAY_EN_BIT] : inter_word_delay_en_reg;
                pend_reg.wait_len <= fmt_i[full_wr ? new_fsel : fsel_reg].inter_word_delay;
            end
        end
    end

    // ----------------------------------------------------------------
    // Master sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_reg <= sct_pkg::ST_IDLE;
            cs_act_reg <= 1'b0;
            w_en_reg <= 1'b0;
            w_len_reg <= 6'h00;
            cnt_reg <= 10'h000;
            tick_reg <= 9'h000;
            sclk_reg <= 1'b0;
        end else if (!module_reset_n_i) begin
            st_reg <= sct_pkg::ST_IDLE;
            cs_act_reg <= 1'b0;
        end else begin
            case (st_reg)
                sct_pkg::ST_IDLE: begin
                    sclk_reg <= fmt.polarity;
                    tick_reg <= half;
                    if (m_start) begin
                        cs_act_reg <= cs_pin_en_i;
                        w_en_reg <= pend_reg.wait_en;
                        w_len_reg <= pend_reg.wait_len;
                        cnt_reg <= setup_len;
                        st_reg <= setup_on ? sct_pkg::ST_SETUP : sct_pkg::ST_SHIFT;
                    end
                end
                sct_pkg::ST_SETUP: begin
                    cnt_reg <= cnt_reg - 10'h001;
                    if (cnt_reg == 10'h001) begin
                        st_reg <= sct_pkg::ST_SHIFT;
                    end
                end
                sct_pkg::ST_SHIFT: begin
                    tick_reg <= (tick_reg == 9'h001) ? half : tick_reg - 9'h001;
                    if (mtick) begin
                        sclk_reg <= ~sclk_reg;
                    end
                    if (mtick && last) begin
                        if (hold_on) begin
                            st_reg <= sct_pkg::ST_HOLD;
                            cnt_reg <= hold_len;
                        end else begin
                            cs_act_reg <= cs_act_reg & cur_keep_reg;
                            st_reg <= w_en_reg ? sct_pkg::ST_WAIT : sct_pkg::ST_IDLE;
                            cnt_reg <= wait_len;
                        end
                    end
                end
                sct_pkg::ST_HOLD: begin
                    cnt_reg <= cnt_reg - 10'h001;
                    if (cnt_reg == 10'h001) begin
                        cs_act_reg <= 1'b0;
                        st_reg <= w_en_reg ? sct_pkg::ST_WAIT : sct_pkg::ST_IDLE;
                        cnt_reg <= wait_len;
                    end
                end
                sct_pkg::ST_WAIT: begin
                    cnt_reg <= cnt_reg - 10'h001;
                    if (cnt_reg == 10'h001) begin
                        st_reg <= sct_pkg::ST_IDLE;
                    end
                end
                default: begin
                    st_reg <= sct_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Shift engine shared by master and slave
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            edge_reg <= 6'h00;
            rxbit_reg <= 1'b0;
            sh_reg <= 16'h0000;
            rx_data_o <= 16'h0000;
            rx_valid_o <= 1'b0;
            slave_ready_o <= 1'b0;
        end else begin
            rx_valid_o <= 1'b0;
            if (is_slave && !sel) begin
                edge_reg <= 6'h00;
            end else if (ev) begin
                edge_reg <= edge_reg + 6'h01;
                if (samp) begin
                    rxbit_reg <= din;
                end
                if (last) begin
                    sh_reg <= word_done;
                    rx_data_o <= word_done;
                    rx_valid_o <= 1'b1;
                    edge_reg <= 6'h00;
                    slave_ready_o <= 1'b0;
                end else if (!samp && !(fmt.phase && edge_reg == 6'h00)) begin
                    sh_reg <= {sh_reg[14:0], rxbit_reg};
                end
            end
            if (m_start || s_load) begin
                sh_reg <= sh_load;
                edge_reg <= 6'h00;
            end
            if (s_load) begin
                slave_ready_o <= 1'b1;
            end
            if (!module_reset_n_i) begin
                slave_ready_o <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign busy_o = (st_reg != sct_pkg::ST_IDLE) | pend_v_reg;
    assign cs_keep_o = cur_keep_reg;
    assign serial_clock_pin_o = sclk_reg;
    assign serial_clock_pin_oe_n_o = ~is_master;
    assign slave_in_pin_o = sh_reg[15];
    assign slave_in_pin_oe_n_o = ~is_master;
    assign slave_out_pin_o = sh_reg[15];
    assign slave_out_pin_oe_n_o = ~(is_slave & sel);
    assign chip_select_pin_n_o = ~cs_act_reg;
    assign chip_select_pin_oe_n_o = ~(is_master & cs_pin_en_i);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    setup_cs_a: assert property ((st_reg == sct_pkg::ST_SETUP) |-> cs_act_reg && !chip_select_pin_n_o)
        else $error("chip select idle during setup");
    setup_len_a: assert property ($rose(st_reg == sct_pkg::ST_SETUP) |-> cnt_reg == setup_len)
        else $error("setup count wrong");
    setup_gate_a: assert property (m_start && !setup_on |=> st_reg == sct_pkg::ST_SHIFT)
        else $error("setup applied when not allowed");
    hold_len_a: assert property ($rose(st_reg == sct_pkg::ST_HOLD) |-> cnt_reg == hold_len && cs_act_reg)
        else $error("hold count wrong");
    wait_len_a: assert property ($rose(st_reg == sct_pkg::ST_WAIT) |-> cnt_reg == wait_len && w_en_reg)
        else $error("wait count wrong");
    keep_cs_a: assert property (mtick && last && cur_keep_reg && cs_act_reg |=> cs_act_reg [*2])
        else $error("chip select dropped while kept");
    keep_rst_a: assert property (!module_reset_n_i |=> !cur_keep_reg && !cs_act_reg)
        else $error("module reset left keep set");
    slave_fsel_a: assert property (tx_wr_i && tx_to_ctrl_i && is_slave |=> fsel_reg == 2'h0)
        else $error("slave format select not cleared");
    pins_mode_a: assert property (is_master |-> !serial_clock_pin_oe_n_o && slave_out_pin_oe_n_o)
        else $error("master pin drive wrong");
    ctrl_nostart_a: assert property (tx_wr_i && !tx_be_i[0] && !tx_be_i[1] && !pend_v_reg |=> !pend_v_reg)
        else $error("control write started transfer");
    rx_just_a: assert property (rx_valid_o |-> (rx_data_o & ~mask) == 16'h0000)
        else $error("received word not right-justified");
endmodule : sct_core

// *** dv/sct_slave_model.sv ***
// Purpose: behavioural serial slave facing the core in master mode
// Assumes: clock polarity 0, phase 0, 8-bit words
// Notes: output shows the inverse of its last bit while deselected
`timescale 1ns/10ps
module sct_slave_model (
    // Serial pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    // Word interface
    input wire logic [7:0] load_i,
    output logic [7:0] rx_o
);
    // ----------------------------------------------------------------
    // Shift logic
    // ----------------------------------------------------------------
    logic [7:0] sh = 8'h00;
    initial begin
        miso_o = 1'b0;
        rx_o = 8'h00;
    end
    always @(negedge cs_n_i) begin
        sh = load_i;
        miso_o = sh[7];
    end
    always @(posedge cs_n_i) begin
        miso_o = ~miso_o;
    end
    always @(posedge sclk_i) begin
        if (cs_n_i === 1'b0) begin
            rx_o = {rx_o[6:0], mosi_i};
        end
    end
    always @(negedge sclk_i) begin
        if (cs_n_i === 1'b0) begin
            sh = {sh[6:0], 1'b0};
            miso_o = sh[7];
        end
    end
endmodule : sct_slave_model

// *** dv/testbench.sv ***
// Purpose: self-checking bench of the transfer core
// Assumes: 100 MHz clock, 160 ns link clock in slave runs
// Notes: delays are judged as differences between runs
`timescale 1ns/10ps
module testbench;
    // ----------------------------------------------------------------
    // Signals and wiring
    // ----------------------------------------------------------------
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic mrst_n = 1'b1, en = 1'b0, csel = 1'b1, msel = 1'b1, cs_en = 1'b1;
    logic [7:0] su = 8'h00, ho = 8'h00;
    sct_pkg::sct_fmt_s [3:0] fmt = '0;
    logic tx_wr = 1'b0, tx_ctrl = 1'b0;
    logic [3:0] tx_be = 4'h0;
    logic [31:0] tx_wd = 32'h0;
    logic [15:0] rx_data_o, rxw = 16'h0;
    logic rx_valid_o, busy_o, slave_ready_o, cs_keep_o, mdl_miso;
    logic sclk_o, sclk_oe_n, simo_o, simo_oe_n, somi_o, somi_oe_n, cs_o, cs_oe_n;
    logic tb_sclk = 1'b0, tb_simo = 1'b0;
    logic [7:0] mdl_rx;
    int error_cnt = 0, n_checks = 0, cyc = 0, s0, h0, h3;
    wire sclk_w = !sclk_oe_n ? sclk_o : tb_sclk;
    wire simo_w = !simo_oe_n ? simo_o : tb_simo;
    wire somi_w = !somi_oe_n ? somi_o : mdl_miso;
    wire cs_w = !cs_oe_n ? cs_o : 1'b1;
    sct_core dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .module_reset_n_i(mrst_n), .enable_i(en),
        .clock_source_sel_i(csel), .master_sel_i(msel), .cs_pin_en_i(cs_en), .cs_setup_delay_i(su),
        .cs_hold_delay_i(ho), .fmt_i(fmt), .tx_wr_i(tx_wr), .tx_to_ctrl_i(tx_ctrl), .tx_be_i(tx_be),
        .tx_wdata_i(tx_wd), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .busy_o(busy_o),
        .slave_ready_o(slave_ready_o), .cs_keep_o(cs_keep_o), .serial_clock_pin_i(sclk_w),
        .serial_clock_pin_o(sclk_o), .serial_clock_pin_oe_n_o(sclk_oe_n), .slave_in_pin_i(simo_w),
        .slave_in_pin_o(simo_o), .slave_in_pin_oe_n_o(simo_oe_n), .slave_out_pin_i(somi_w),
        .slave_out_pin_o(somi_o), .slave_out_pin_oe_n_o(somi_oe_n), .chip_select_pin_n_i(cs_w),
        .chip_select_pin_n_o(cs_o), .chip_select_pin_oe_n_o(cs_oe_n));
    sct_slave_model mdl (.sclk_i(sclk_w), .cs_n_i(cs_w), .mosi_i(simo_w), .miso_o(mdl_miso),
        .load_i(8'hC3), .rx_o(mdl_rx));
    // ----------------------------------------------------------------
    // Clock, watchdog, capture and helpers
    // ----------------------------------------------------------------
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (rx_valid_o === 1'b1) begin
            rxw <= rx_data_o;
        end
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic ctrl, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk_i);
        #1;
        tx_wr = 1'b1;
        tx_ctrl = ctrl;
        tx_be = be;
        tx_wd = d;
        @(posedge clk_i);
        #1;
        tx_wr = 1'b0;
    endtask : wr
    // Cycles from write to first clock edge, and from last edge to idle
    task automatic mword(input logic ctrl, input logic [3:0] be, input logic keep, input logic wen,
        output int ts, output int te);
        int i, fe, le;
        logic ps;
        fe = -1;
        le = 0;
        @(posedge clk_i);
        #1;
        en = 1'b1;
        wr(ctrl, be, {3'h0, keep, 1'b0, wen, 10'h000, 16'h005A});
        ps = sclk_o;
        for (i = 1; i < 3000; i++) begin
            @(posedge clk_i);
            #1;
            if (sclk_o !== ps) begin
                if (fe < 0) fe = i;
                le = i;
            end
            ps = sclk_o;
            if (busy_o !== 1'b1 && i > 2) break;
        end
        ts = fe;
        te = i - le;
        en = 1'b0;
    endtask : mword
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_timing;
        int s5, h3p0, w, e, x;
        chk({sclk_oe_n, simo_oe_n, somi_oe_n}, 3'b001);
        su = 8'h00; ho = 8'h03; fmt[0].phase = 1'b1;
        mword(1'b1, 4'hF, 1'b0, 1'b0, s0, h3);
        su = 8'h05; ho = 8'h00;
        mword(1'b1, 4'hF, 1'b0, 1'b0, s5, h0);
        chk(s5 - s0, 7);
        chk(h3 - h0, 4);
        ho = 8'h03; fmt[0].phase = 1'b0;
        mword(1'b1, 4'hF, 1'b0, 1'b0, x, h3p0);
        chk(h3p0 - h3, 5);
        chk(rxw[7:0], 8'hC3);
        chk(mdl_rx, 8'h5A);
        chk(cs_w, 1'b1);
        fmt[0].phase = 1'b1; su = 8'h00;
        mword(1'b1, 4'hF, 1'b0, 1'b1, x, w);
        chk(w - h3, 7);
        mword(1'b0, 4'h3, 1'b0, 1'b0, x, e);
        chk(e, w);
        mword(1'b1, 4'hF, 1'b0, 1'b0, x, e);
        chk(e, h3);
        cs_en = 1'b0; su = 8'h05;
        mword(1'b1, 4'hF, 1'b0, 1'b0, x, e);
        chk(x, s0);
        chk(e, h0);
        chk(cs_oe_n, 1'b1);
        cs_en = 1'b1;
    endtask : t_timing
    task automatic t_keep;
        int x, e;
        mword(1'b1, 4'hF, 1'b1, 1'b0, x, e);
        chk(cs_w, 1'b0);
        mword(1'b1, 4'hF, 1'b0, 1'b0, x, e);
        chk(x, s0);
        chk(e, h3);
        chk(cs_w, 1'b1);
    endtask : t_keep
    task automatic t_ctrl;
        wr(1'b1, 4'h8, 32'h1000_0000);
        repeat (3) begin
            chk(busy_o, 1'b0);
            @(posedge clk_i);
            #1;
        end
        chk(cs_keep_o, 1'b1);
        mrst_n = 1'b0;
        @(posedge clk_i);
        #1;
        mrst_n = 1'b1;
        chk(cs_keep_o, 1'b0);
    endtask : t_ctrl
    task automatic t_slave;
        int i;
        logic [7:0] got;
        en = 1'b0;
        csel = 1'b0; msel = 1'b0; cs_en = 1'b0;
        fmt[0].phase = 1'b0; fmt[1].word_length = 5'h04;
        @(posedge clk_i);
        #1;
        en = 1'b1;
        chk({sclk_oe_n, simo_oe_n, somi_oe_n}, 3'b110);
        wr(1'b1, 4'h8, 32'h0100_0000);
        chk(slave_ready_o, 1'b0);
        wr(1'b1, 4'hF, 32'h0100_003C);
        chk(slave_ready_o, 1'b1);
        for (i = 7; i >= 0; i--) begin
            tb_simo = i[0] ^ i[1];
            #80;
            tb_sclk = 1'b1;
            got[i] = somi_w;
            #80;
            tb_sclk = 1'b0;
        end
        repeat (6) @(posedge clk_i);
        #1;
        chk(rxw, 16'h0066);
        chk(slave_ready_o, 1'b0);
        chk(got, 8'h3C);
    endtask : t_slave
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        fmt[0] = '{8'h04, 5'h08, 6'h05, 1'b1, 1'b0};
        fmt[1] = '{8'h04, 5'h08, 6'h05, 1'b1, 1'b0};
        repeat (5) @(posedge clk_i);
        #1;
        reset_n_i = 1'b1;
        t_timing();
        t_keep();
        t_ctrl();
        t_slave();
        report_and_stop();
    end
endmodule : testbench
